// File: design/fmx_ea_check.sv
`timescale 1ns/1ps
`default_nettype none
module fmx_ea_check
    import fmx_pkg::*;
(
    input  wire logic [2:0] mode,
    input  wire logic [2:0] regno,
    output logic            data_alt_ok,
    output logic            data_src_ok
);
    // Data alterable: data reg, memory modes, absolute short or long
    function automatic logic is_data_alt(input logic [2:0] m,
                                         input logic [2:0] r);
        is_data_alt = (m == MODE_DREG) ||
                      (m >= MODE_IND && m <= MODE_INDEX) ||
                      (m == MODE_EXT && (r == EXT_ABS_W || r == EXT_ABS_L));
    endfunction

    // Data modes: everything but address direct, up to immediate
    function automatic logic is_data(input logic [2:0] m,
                                     input logic [2:0] r);
        is_data = (m != MODE_AREG) && (m != MODE_EXT || r <= EXT_IMM);
    endfunction

    assign data_alt_ok = is_data_alt(mode, regno);
    assign data_src_ok = is_data(mode, regno);
endmodule
`default_nettype wire

// File: design/fmx_exec.sv
`timescale 1ns/1ps
`default_nettype none
module fmx_exec
    import fmx_pkg::*;
(
    input  wire logic           mclk,
    input  wire logic           reset,
    input  wire logic           instr_valid,
    output logic                instr_ready,
    input  wire logic [15:0]    instr_opword,
    input  wire logic [15:0]    instr_ext1,
    input  wire logic [15:0]    instr_ext2,
    input  wire logic [7:0]     status_hi_byte,
    output logic      [7:0]     condition_flags,
    output logic                exec_done,
    output logic                illegal_instr,
    output logic                opnd_valid,
    output fmx_opnd_req_t       opnd_req,
    input  wire logic           opnd_ready,
    input  wire logic [15:0]    opnd_rdata,
    output logic      [2:0]     ptr_rd_sel,
    input  wire logic [31:0]    ptr_rd_data,
    output logic                ptr_wr_en,
    output logic      [2:0]     ptr_wr_sel,
    output logic      [31:0]    ptr_wr_data,
    output logic                burst_valid,
    output fmx_burst_req_t      burst_req,
    input  wire logic           burst_ready,
    input  wire logic           rbeat_valid,
    output logic                rbeat_ready,
    input  wire logic [31:0]    rbeat_data,
    output logic                wbeat_valid,
    input  wire logic           wbeat_ready,
    output logic      [31:0]    wbeat_data
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fmx_state_t  state_reg, state_next;
    logic [7:0]  flags_reg, flags_next;
    logic        load_reg, load_next;
    logic [2:0]  mode_reg, mode_next;
    logic [2:0]  regno_reg, regno_next;
    logic [15:0] wdata_reg, wdata_next;
    logic [31:0] src_reg, src_next;
    logic [31:0] dst_reg, dst_next;
    logic [2:0]  src_sel_reg, src_sel_next;
    logic [2:0]  dst_sel_reg, dst_sel_next;
    logic        inc_src_reg, inc_src_next;
    logic        inc_dst_reg, inc_dst_next;
    logic [1:0]  beat_reg, beat_next;
    logic [31:0] hold_reg [4];

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [2:0]  ea_mode;
    logic [2:0]  ea_regno;
    logic [1:0]  lc_var;
    logic [31:0] abs_addr;
    logic        is_from_flags;
    logic        is_to_flags;
    logic        is_from_status;
    logic        is_lc_post;
    logic        is_lc_abs;
    logic        data_alt_ok;
    logic        data_src_ok;
    logic        is_legal;
    logic        accept;
    logic [15:0] flags_word;
    logic [15:0] status_word;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic        rd_fire;
    logic        wr_fire;
    logic [1:0]  rd_slot;
    logic [1:0]  wr_slot;

    assign ea_mode  = instr_opword[EA_MODE_LSB +: 3];
    assign ea_regno = instr_opword[EA_REG_LSB +: 3];
    assign lc_var   = instr_opword[LC_OPMODE_LSB +: 2];
    assign abs_addr = {instr_ext1, instr_ext2};

    assign is_from_flags  = instr_opword[OPW_CLASS_LSB +: 10] == OP_FROM_FLAGS;
    assign is_to_flags    = instr_opword[OPW_CLASS_LSB +: 10] == OP_TO_FLAGS;
    assign is_from_status =
        instr_opword[OPW_CLASS_LSB +: 10] == OP_FROM_STATUS;
    assign is_lc_post = (instr_opword[OPW_LCPOST_LSB +: 13] == OP_LC_POST) &&
                        ((instr_ext1 & LC_EXT_MARK) != '0) &&
                        ((instr_ext1 & LC_EXT_ZERO) == '0);
    assign is_lc_abs  = instr_opword[OPW_LCABS_LSB +: 11] == OP_LC_ABS;

    fmx_ea_check u_ea_check (
        .mode        (ea_mode),
        .regno       (ea_regno),
        .data_alt_ok (data_alt_ok),
        .data_src_ok (data_src_ok)
    );

    // Only permitted mode/register pairs execute
    assign is_legal = (is_from_flags  && data_alt_ok) ||
                      (is_from_status && data_alt_ok) ||
                      (is_to_flags    && data_src_ok) ||
                      is_lc_post || is_lc_abs;
    assign instr_ready   = (state_reg == ST_IDLE);
    assign accept        = instr_valid && instr_ready;
    assign illegal_instr = accept && !is_legal;

    // Words written out; unimplemented positions forced to zero
    assign flags_word  = {ZERO_BYTE, flags_reg & FLAGS_IMPL_MASK};
    assign status_word = {status_hi_byte & STATUS_HI_MASK,
                          flags_reg & FLAGS_IMPL_MASK};

    // ------------------------------------------------------------
    // Bus-facing outputs
    // ------------------------------------------------------------
    assign condition_flags = flags_reg;
    assign opnd_valid      = (state_reg == ST_OPND_RD) ||
                             (state_reg == ST_OPND_WR);
    assign opnd_req.write  = (state_reg == ST_OPND_WR);
    assign opnd_req.mode   = mode_reg;
    assign opnd_req.regno  = regno_reg;
    assign opnd_req.size   = SIZE_WORD;
    assign opnd_req.wdata  = wdata_reg;

    assign ptr_rd_sel = (state_reg == ST_IDLE) ? ea_regno : dst_sel_reg;
    assign ptr_wr_en  = ((state_reg == ST_LC_PSRC) && inc_src_reg) ||
                        ((state_reg == ST_LC_PDST) && inc_dst_reg);
    assign ptr_wr_sel = (state_reg == ST_LC_PSRC) ? src_sel_reg : dst_sel_reg;
    assign ptr_wr_data = (state_reg == ST_LC_PSRC) ?
                         src_reg + LINE_BYTES :
                         dst_reg + LINE_BYTES;

    // Each burst starts at the long word named by its address
    assign burst_valid     = (state_reg == ST_LC_RREQ) ||
                             (state_reg == ST_LC_WREQ);
    assign burst_req.write = (state_reg == ST_LC_WREQ);
    assign burst_req.addr  = burst_req.write ? dst_reg : src_reg;

    // Read beats land in line slots starting at the source word
    assign fifo_out_ready = (state_reg == ST_LC_RDAT);
    assign rd_fire  = fifo_out_valid && fifo_out_ready;
    assign rd_slot  = src_reg[LINE_WORD_LSB +: 2] + beat_reg;
    assign wr_slot  = dst_reg[LINE_WORD_LSB +: 2] + beat_reg;
    assign wbeat_valid = (state_reg == ST_LC_WDAT);
    assign wbeat_data  = hold_reg[wr_slot];
    assign wr_fire     = wbeat_valid && wbeat_ready;

    fmx_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .reset     (reset),
        .in_valid  (rbeat_valid),
        .in_ready  (rbeat_ready),
        .in_data   (rbeat_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .full      (),
        .empty     ()
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next   = state_reg;
        flags_next   = flags_reg;
        load_next    = load_reg;
        mode_next    = mode_reg;
        regno_next   = regno_reg;
        wdata_next   = wdata_reg;
        src_next     = src_reg;
        dst_next     = dst_reg;
        src_sel_next = src_sel_reg;
        dst_sel_next = dst_sel_reg;
        inc_src_next = inc_src_reg;
        inc_dst_next = inc_dst_reg;
        beat_next    = beat_reg;
        exec_done    = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (accept && is_legal) begin
                    mode_next  = ea_mode;
                    regno_next = ea_regno;
                    load_next  = is_to_flags;
                    if (is_from_flags) begin
                        wdata_next = flags_word;
                        state_next = ST_OPND_WR;
                    end else if (is_to_flags) begin
                        state_next = ST_OPND_RD;
                    end else if (is_from_status) begin
                        wdata_next = status_word;
                        state_next = (ea_mode == MODE_DREG) ?
                                     ST_OPND_WR : ST_OPND_RD;
                    end else if (is_lc_post) begin
                        src_next     = ptr_rd_data;
                        src_sel_next = ea_regno;
                        dst_sel_next =
                            instr_ext1[LC_DST_REG_LSB +: 3];
                        inc_src_next = 1'b1;
                        inc_dst_next = 1'b1;
                        state_next   = ST_LC_DST;
                    end else begin
                        src_sel_next = ea_regno;
                        dst_sel_next = ea_regno;
                        inc_src_next = !lc_var[LC_VAR_NO_INC] &&
                                       !lc_var[LC_VAR_SRC_ABS];
                        inc_dst_next = !lc_var[LC_VAR_NO_INC] &&
                                       lc_var[LC_VAR_SRC_ABS];
                        src_next = lc_var[LC_VAR_SRC_ABS] ?
                                   abs_addr : ptr_rd_data;
                        dst_next = lc_var[LC_VAR_SRC_ABS] ?
                                   ptr_rd_data : abs_addr;
                        state_next = ST_LC_RREQ;
                    end
                end
            end
            ST_OPND_RD: begin
                if (opnd_ready) begin
                    if (load_reg) begin
                        flags_next = {3'h0, opnd_rdata[4:0]};
                        exec_done  = 1'b1;
                        state_next = ST_IDLE;
                    end else begin
                        state_next = ST_OPND_WR;
                    end
                end
            end
            ST_OPND_WR: begin
                if (opnd_ready) begin
                    exec_done  = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_LC_DST: begin
                dst_next   = ptr_rd_data;
                state_next = ST_LC_RREQ;
            end
            ST_LC_RREQ: begin
                beat_next = 2'h0;
                if (burst_ready) begin
                    state_next = ST_LC_RDAT;
                end
            end
            ST_LC_RDAT: begin
                if (rd_fire) begin
                    beat_next = beat_reg + 2'h1;
                    if (beat_reg == LAST_BEAT) begin
                        state_next = ST_LC_WREQ;
                    end
                end
            end
            ST_LC_WREQ: begin
                beat_next = 2'h0;
                if (burst_ready) begin
                    state_next = ST_LC_WDAT;
                end
            end
            ST_LC_WDAT: begin
                if (wr_fire) begin
                    beat_next = beat_reg + 2'h1;
                    if (beat_reg == LAST_BEAT) begin
                        state_next = ST_LC_PSRC;
                    end
                end
            end
            ST_LC_PSRC: begin
                state_next = ST_LC_PDST;
            end
            ST_LC_PDST: begin
                exec_done  = 1'b1;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Holding register for the whole source line
    always_ff @(posedge mclk) begin
        if (rd_fire) begin
            hold_reg[rd_slot] <= fifo_out_data;
        end
    end

    // Control registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            flags_reg <= FLAGS_RESET;
            load_reg  <= 1'b0;
            beat_reg  <= 2'h0;
        end else begin
            state_reg <= state_next;
            flags_reg <= flags_next;
            load_reg  <= load_next;
            beat_reg  <= beat_next;
        end
    end

    // Operand and address holding
    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_reg    <= '0;
            regno_reg   <= '0;
            wdata_reg   <= '0;
            src_reg     <= '0;
            dst_reg     <= '0;
            src_sel_reg <= '0;
            dst_sel_reg <= '0;
            inc_src_reg <= 1'b0;
            inc_dst_reg <= 1'b0;
        end else begin
            mode_reg    <= mode_next;
            regno_reg   <= regno_next;
            wdata_reg   <= wdata_next;
            src_reg     <= src_next;
            dst_reg     <= dst_next;
            src_sel_reg <= src_sel_next;
            dst_sel_reg <= dst_sel_next;
            inc_src_reg <= inc_src_next;
            inc_dst_reg <= inc_dst_next;
        end
    end
endmodule
`default_nettype wire

// File: design/fmx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module fmx_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  full,
    output logic                  empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             push;
    logic             pop;

    // Status from pointer comparison
    assign empty     = (wr_ptr_reg == rd_ptr_reg);
    assign full      = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
                       (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;
    assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

    // Storage
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// File: design/fmx_pkg.sv
package fmx_pkg;

    // ------------------------------------------------------------
    // Opcode patterns
    // ------------------------------------------------------------
    localparam logic [9:0]  OP_FROM_FLAGS   = 10'h10b; // opword[15:6]
    localparam logic [9:0]  OP_TO_FLAGS     = 10'h113; // opword[15:6]
    localparam logic [9:0]  OP_FROM_STATUS  = 10'h103; // opword[15:6]
    localparam logic [12:0] OP_LC_POST      = 13'h1ec4; // opword[15:3]
    localparam logic [10:0] OP_LC_ABS       = 11'h7b0; // opword[15:5]
    localparam logic [15:0] LC_EXT_MARK     = 16'h8000;
    localparam logic [15:0] LC_EXT_ZERO     = 16'h0fff;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int OPW_CLASS_LSB    = 6;
    localparam int OPW_LCPOST_LSB   = 3;
    localparam int OPW_LCABS_LSB    = 5;
    localparam int EA_REG_LSB       = 0;
    localparam int EA_MODE_LSB      = 3;
    localparam int LC_OPMODE_LSB    = 3;
    localparam int LC_DST_REG_LSB   = 12;
    localparam int LINE_WORD_LSB    = 2;

    // ------------------------------------------------------------
    // Addressing mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_DREG    = 3'h0;
    localparam logic [2:0] MODE_AREG    = 3'h1;
    localparam logic [2:0] MODE_IND     = 3'h2;
    localparam logic [2:0] MODE_INDEX   = 3'h6;
    localparam logic [2:0] MODE_EXT     = 3'h7;
    localparam logic [2:0] EXT_ABS_W    = 3'h0;
    localparam logic [2:0] EXT_ABS_L    = 3'h1;
    localparam logic [2:0] EXT_IMM      = 3'h4;

    // Line copy variant bits: [0] source is absolute, [1] no increment
    localparam int LC_VAR_SRC_ABS = 0;
    localparam int LC_VAR_NO_INC  = 1;

    // ------------------------------------------------------------
    // Flags and status word
    // ------------------------------------------------------------
    localparam logic [7:0] FLAGS_RESET      = 8'h00;
    localparam logic [7:0] FLAGS_IMPL_MASK  = 8'h1f;
    localparam logic [7:0] STATUS_HI_MASK   = 8'hff;
    localparam logic [7:0] ZERO_BYTE        = 8'h00;

    // ------------------------------------------------------------
    // Operand sizes and line geometry
    // ------------------------------------------------------------
    localparam logic [1:0]  SIZE_BYTE       = 2'h0;
    localparam logic [1:0]  SIZE_WORD       = 2'h1;
    localparam logic [1:0]  SIZE_LONG       = 2'h2;
    localparam logic [31:0] LINE_BYTES      = 32'h10;
    localparam logic [1:0]  LAST_BEAT       = 2'h3;
    localparam int          FIFO_WIDTH      = 32;
    localparam int          FIFO_DEPTH      = 32;

    // ------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic        write;
        logic [2:0]  mode;
        logic [2:0]  regno;
        logic [1:0]  size;
        logic [15:0] wdata;
    } fmx_opnd_req_t;

    typedef struct packed {
        logic        write;
        logic [31:0] addr;
    } fmx_burst_req_t;

    typedef enum logic [9:0] {
        ST_IDLE    = 10'h001,
        ST_OPND_RD = 10'h002,
        ST_OPND_WR = 10'h004,
        ST_LC_DST  = 10'h008,
        ST_LC_RREQ = 10'h010,
        ST_LC_RDAT = 10'h020,
        ST_LC_WREQ = 10'h040,
        ST_LC_WDAT = 10'h080,
        ST_LC_PSRC = 10'h100,
        ST_LC_PDST = 10'h200
    } fmx_state_t;

endpackage

// File: testbench/fmx_exec_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fmx_exec_asserts
    import fmx_pkg::*;
(
    input wire logic           mclk,
    input wire logic           reset,
    input wire logic           instr_ready,
    input wire logic [15:0]    instr_opword,
    input wire logic [7:0]     status_hi_byte,
    input wire logic [7:0]     condition_flags,
    input wire logic           exec_done,
    input wire logic           illegal_instr,
    input wire logic           opnd_valid,
    input wire fmx_opnd_req_t  opnd_req,
    input wire logic           opnd_ready,
    input wire logic [15:0]    opnd_rdata,
    input wire logic           burst_valid,
    input wire fmx_burst_req_t burst_req,
    input wire logic           burst_ready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic [15:0] op_q;
    wire rd_done = opnd_valid && opnd_ready && !opnd_req.write;
    wire is_ld = op_q[15:6] == OP_TO_FLAGS;
    wire is_st = op_q[15:6] == OP_FROM_STATUS;
    // Opcode of the operation in flight
    always_ff @(posedge mclk) begin
        if (reset) begin
            op_q <= 16'h0000;
        end else if (instr_ready) begin
            op_q <= instr_opword;
        end
    end
    sequence s_rd_go; burst_valid && burst_ready && !burst_req.write;
    endsequence
    sequence s_wr_go; burst_valid && burst_ready && burst_req.write;
    endsequence
    property p_size; opnd_valid |-> opnd_req.size == SIZE_WORD; endproperty
    a_size: assert property (p_size) else $error("size");
    property p_flagrd; opnd_valid && opnd_req.write
        && op_q[15:6] == OP_FROM_FLAGS
        |-> opnd_req.wdata == {11'h000, condition_flags[4:0]}; endproperty
    a_flagrd: assert property (p_flagrd) else $error("rd");
    property p_flagld; rd_done && is_ld
        |=> condition_flags == {3'h0, $past(opnd_rdata[4:0])}; endproperty
    a_flagld: assert property (p_flagld) else $error("ld");
    property p_hold; !(rd_done && is_ld) |=> $stable(condition_flags);
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_status; rd_done && is_st |=> opnd_valid && opnd_req.write
        && opnd_req.wdata == {status_hi_byte, 3'h0, condition_flags[4:0]};
    endproperty
    a_status: assert property (p_status) else $error("st");
    property p_illegal; illegal_instr
        |=> instr_ready && !opnd_valid && !burst_valid; endproperty
    a_illegal: assert property (p_illegal) else $error("ill");
    property p_lc_steps; s_rd_go |=> !burst_valid [*4]; endproperty
    a_lc_steps: assert property (p_lc_steps) else $error("lc");
    property p_wr_done; s_wr_go |-> ##[4:400] exec_done; endproperty
    a_wr_done: assert property (p_wr_done) else $error("wr");
endmodule
bind fmx_exec fmx_exec_asserts u_chk (.*);
`default_nettype wire

// File: testbench/fmx_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fmx_exec_tb
    import fmx_pkg::*;
();
    logic mclk = 1'h0, reset = 1'h1, slow = 1'h0, instr_valid = 1'h0;
    logic [15:0] instr_opword = 16'h0000, instr_ext1 = 16'h0000, wd;
    logic [15:0] instr_ext2 = 16'h0000, src_word = 16'hffea, opnd_rdata;
    logic [7:0] status_hi_byte = 8'h27, condition_flags, bad = 8'hd7;
    logic instr_ready, exec_done, illegal_instr, opnd_valid, opnd_ready;
    logic burst_valid, burst_ready, rbeat_valid, rbeat_ready, ptr_wr_en;
    logic wbeat_valid, wbeat_ready, ill;
    logic [7:0] wsz;
    logic [2:0] ptr_rd_sel, ptr_wr_sel;
    logic [31:0] ptr_rd_data, ptr_wr_data, rbeat_data, wbeat_data, src, dst;
    logic [31:0] ptr [8], ba [2], p5 = 32'h00020004;
    logic [127:0] wline;
    logic [15:0] ops [8] = '{16'h42c8, 16'h42fc, 16'h42fa, 16'h42f9,
                             16'h44c8, 16'h44fa, 16'h40c9, 16'h40fc};
    fmx_opnd_req_t opnd_req;
    fmx_burst_req_t burst_req;
    int fail_count = 0, comparisons = 0, nrd, rdb;
    fmx_exec dut (.*);
    fmx_mem_model mem (.*);
    assign ptr_rd_data = ptr[ptr_rd_sel];
    always #2.5 mclk = ~mclk;
    // Records operand, burst and pointer traffic
    always @(posedge mclk) begin
        if (opnd_valid && opnd_ready) begin
            wsz = {opnd_req.mode, opnd_req.regno, opnd_req.size};
            if (opnd_req.write) begin
                wd = opnd_req.wdata;
                rdb = nrd;
            end else nrd++;
        end
        if (burst_valid && burst_ready) ba[burst_req.write] = burst_req.addr;
        if (ptr_wr_en) ptr[ptr_wr_sel] <= ptr_wr_data;
    end
    function automatic logic [127:0] lw(input logic [31:0] a);
        lw = {a[31:4], 4'hc, a[31:4], 4'h8, a[31:4], 4'h4, a[31:4], 4'h0};
    endfunction
    task automatic check(input logic [127:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One instruction, waiting a bounded time for its completion
    task automatic run(input logic [15:0] op, e1, e2);
        int n;
        n = 0;
        nrd = 0;
        @(posedge mclk);
        instr_valid <= 1'h1;
        instr_opword <= op;
        instr_ext1 <= e1;
        instr_ext2 <= e2;
        @(negedge mclk);
        ill = illegal_instr;
        @(posedge mclk);
        instr_valid <= 1'h0;
        while (!ill && exec_done !== 1'h1 && n < 300) begin
            @(negedge mclk);
            n++;
        end
        if (n == 300) begin
            fail_count++;
            complete_run();
        end
        @(negedge mclk);
    endtask
    // Flag moves, encoding table, then both line copy forms
    initial begin
        ptr[1] = 32'h0001400c;
        ptr[3] = 32'h000fe804;
        ptr[5] = p5;
        repeat (6) @(posedge mclk);
        reset <= 1'h0;
        @(negedge mclk);
        check(condition_flags, FLAGS_RESET);
        run(16'h44c0, 16'h0000, 16'h0000);
        check(condition_flags, 8'h0a);
        check(wsz, {6'h00, SIZE_WORD});
        src_word = 16'h0015;
        run(16'h44fc, 16'h0000, 16'h0000);
        check(condition_flags, 8'h15);
        run(16'h42d2, 16'h0000, 16'h0000);
        check(wd, 16'h0015);
        check(wsz, {6'h12, SIZE_WORD});
        run(16'h40d2, 16'h0000, 16'h0000);
        check({wd, rdb[7:0]}, 24'h271501);
        run(16'h40c0, 16'h0000, 16'h0000);
        check({wd, rdb[7:0]}, 24'h271500);
        for (int i = 0; i < 8; i++) begin
            run(ops[i], 16'h0000, 16'h0000);
            check(ill, bad[i]);
        end
        slow = 1'h1;
        run(16'hf621, 16'hb000, 16'h0000);
        check({ba[0], ba[1]}, 64'h0001400c_000fe804);
        check(wline, lw(32'h0001400c));
        check({ptr[1], ptr[3]}, 64'h0001401c_000fe814);
        for (int v = 0; v < 4; v++) begin
            src = v[0] ? 32'h000fe808 : p5;
            dst = v[0] ? p5 : 32'h000fe808;
            run(16'hf605 | 16'(v * 8), 16'h000f, 16'he808);
            check({ba[0], ba[1]}, {src, dst});
            check(wline, lw(src));
            p5 = v[1] ? p5 : p5 + 32'h10;
            check(ptr[5], p5);
        end
        complete_run();
    end
endmodule
`default_nettype wire

// File: testbench/fmx_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module fmx_mem_model
    import fmx_pkg::*;
(
    input  wire logic           mclk,
    input  wire logic           reset,
    input  wire logic           slow,
    input  wire logic [15:0]    src_word,
    input  wire logic           opnd_valid,
    output logic                opnd_ready,
    output logic      [15:0]    opnd_rdata,
    input  wire logic           burst_valid,
    input  wire fmx_burst_req_t burst_req,
    output logic                burst_ready,
    output logic                rbeat_valid,
    input  wire logic           rbeat_ready,
    output logic      [31:0]    rbeat_data,
    input  wire logic           wbeat_valid,
    output logic                wbeat_ready,
    input  wire logic [31:0]    wbeat_data,
    output logic      [127:0]   wline
);
    logic [31:0] ra, wa;
    logic [2:0]  ri, wi;
    logic [1:0]  cnt;
    logic [31:0] wl [4];
    wire         go = !slow || cnt == 2'h3;
    wire  [31:0] rword = {ra[31:4], ra[3:2] + ri[1:0], 2'h0};
    // Slow mode answers every fourth cycle, except read beats, which come every cycle; idle data shows inverted
    assign opnd_ready  = opnd_valid && go;
    assign opnd_rdata  = opnd_ready ? src_word : ~src_word;
    assign burst_ready = burst_valid && go;
    assign rbeat_valid = !ri[2];
    assign rbeat_data  = rbeat_valid ? rword : ~rword;
    assign wbeat_ready = !wi[2] && go;
    assign wline       = {wl[3], wl[2], wl[1], wl[0]};
    // Beats wrap round the line from the addressed long word
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt <= 2'h0;
            ri  <= 3'h4;
            wi  <= 3'h4;
        end else begin
            cnt <= cnt + 2'h1;
            if (burst_ready && !burst_req.write) begin
                ra <= burst_req.addr;
                ri <= 3'h0;
            end
            if (burst_ready && burst_req.write) begin
                wa <= burst_req.addr;
                wi <= 3'h0;
            end
            if (rbeat_valid && rbeat_ready) begin
                ri <= ri + 3'h1;
            end
            if (wbeat_valid && wbeat_ready) begin
                wl[wa[3:2] + wi[1:0]] <= wbeat_data;
                wi <= wi + 3'h1;
            end
        end
    end
endmodule
`default_nettype wire
